// file: src/flash_block_protect_defs.vh
// constants for the flash block-protection logic
`ifndef FLASH_BLOCK_PROTECT_DEFS_VH
`define FLASH_BLOCK_PROTECT_DEFS_VH

// ****************************************************************
// register addresses
// ****************************************************************
`define MAIN_PROTECT_ADDR    16'hfe08
`define FONT_PROTECT_ADDR    16'hfe0b
`define PROTECT_STATUS_ADDR  16'hfe0f

// ****************************************************************
// register fields and reset values
// ****************************************************************
`define PROTECT_RESET        7'h00
`define PROTECT_BITS_MSB     7
`define PROTECT_BITS_LSB     1
`define PROTECT_LOW_ZEROS    9'h000
`define READ_IDLE            8'h00
`define STAT_LATCHED_LSB     0
`define STAT_HV_LSB          2
`define STAT_REFUSED_LSB     4
`define STAT_PAD             2'h0

// ****************************************************************
// array bounds and special encodings
// ****************************************************************
`define MAIN_ARRAY_FIRST     16'h4000
`define MAIN_ARRAY_LAST      16'hffff
`define FONT_ARRAY_FIRST     16'h0c00
`define FONT_ARRAY_LAST      16'h3fff
`define VECTOR_AREA_FIRST    16'hffe0
`define VECTOR_CODE_A        7'h7d
`define VECTOR_CODE_B        7'h7e
`define VECTOR_CODE_C        7'h7f

`endif

// file: src/reset_release_sync.v
// reset synchroniser: asynchronous assert, two-flop release
`timescale 1ns/1ps

module reset_release_sync (
  input  wire core_clk_i,   // system clock
  input  wire reset_n_i,    // raw asynchronous reset, active low
  output reg  sync_reset_n_o // released two edges after the pin
);

  reg stage_n;

  // ****************************************************************
  // release chain
  // ****************************************************************
  // only the second flop is read outside, so a metastable first
  // stage never reaches the design
  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      stage_n        <= 1'b0;
      sync_reset_n_o <= 1'b0;
    end else begin
      stage_n        <= 1'b1;
      sync_reset_n_o <= stage_n;
    end
  end

endmodule // reset_release_sync

// file: src/protect_range.v
// decodes one protect register into array hit and protection result
`timescale 1ns/1ps
`include "flash_block_protect_defs.vh"

module protect_range #(
  parameter [15:0] ARRAY_FIRST  = `MAIN_ARRAY_FIRST, // first array byte
  parameter [15:0] ARRAY_LAST   = `MAIN_ARRAY_LAST,  // last array byte
  parameter        VECTOR_GUARD = 1                  // vector-only codes
) (
  input  wire [6:0]  start_bits_i,   // protect register bits 7..1
  input  wire [15:0] addr_i,         // address to classify
  output wire        in_array_o,     // addr falls in this array
  output wire        protected_hit_o // addr falls in protected region
);

  // ****************************************************************
  // helpers
  // ****************************************************************
  function in_span;
    input [15:0] a;
    input [15:0] lo;
    input [15:0] hi;
    begin
      in_span = (a >= lo) && (a <= hi);
    end
  endfunction

  function is_vector_code;
    input [6:0] b;
    begin
      is_vector_code = (b == `VECTOR_CODE_A) || (b == `VECTOR_CODE_B) ||
                       (b == `VECTOR_CODE_C);
    end
  endfunction

  // ****************************************************************
  // decode
  // ****************************************************************
  wire [15:0] start_addr = {start_bits_i, `PROTECT_LOW_ZEROS};
  wire        vector_only = (VECTOR_GUARD != 0) &&
                            is_vector_code(start_bits_i);
  // a start outside the array leaves it wholly open
  wire        start_valid = in_span(start_addr, ARRAY_FIRST,
                                    ARRAY_LAST);

  assign in_array_o = in_span(addr_i, ARRAY_FIRST, ARRAY_LAST);

  // a start equal to the first byte covers the whole array
  assign protected_hit_o =
    vector_only ? in_span(addr_i, `VECTOR_AREA_FIRST, ARRAY_LAST) :
    start_valid ? in_span(addr_i, start_addr, ARRAY_LAST) :
    1'b0;

endmodule // protect_range

// file: src/flash_block_protect.v
// block protection of the main and font flash arrays
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
`include "flash_block_protect_defs.vh"

module flash_block_protect #(
  parameter ADDR_W = 16, // cpu address width
  parameter DATA_W = 8   // register data width
) (
  input  wire              core_clk_i,           // system clock
  input  wire              reset_n_i,            // async reset, active low
  input  wire [ADDR_W-1:0] reg_addr_i,           // register address
  input  wire [DATA_W-1:0] reg_wdata_i,          // register write data
  input  wire              reg_write_i,          // register write strobe
  input  wire              reg_read_i,           // register read strobe
  output reg  [DATA_W-1:0] reg_rdata_o,          // read data, next cycle
  input  wire              flash_write_i,        // cpu write into flash
  input  wire [ADDR_W-1:0] flash_addr_i,         // cpu flash write address
  input  wire              main_program_select_i, // main program select
  input  wire              main_erase_select_i,  // main erase select
  input  wire              main_hv_request_i,    // main hv bit as written
  input  wire              font_program_select_i, // font program select
  input  wire              font_erase_select_i,  // font erase select
  input  wire              font_hv_request_i,    // font hv bit as written
  output reg               main_high_voltage_enable_o, // main hv granted
  output reg               font_high_voltage_enable_o, // font hv granted
  output reg  [ADDR_W-1:0] main_target_addr_o,   // main latched address
  output reg  [ADDR_W-1:0] font_target_addr_o,   // font latched address
  output reg               main_target_protected_o, // main target guarded
  output reg               font_target_protected_o, // font target guarded
  output reg               main_hv_refused_o,    // main refusal pulse
  output reg               font_hv_refused_o     // font refusal pulse
);

  // ****************************************************************
  // reset release
  // ****************************************************************
  wire rst_n;

  reset_release_sync u_reset_sync (
    .core_clk_i   (core_clk_i),
    .reset_n_i    (reset_n_i),
    .sync_reset_n_o (rst_n)
  );

  // ****************************************************************
  // register decode
  // ****************************************************************
  function hit;
    input [ADDR_W-1:0] a;
    input [15:0]       target;
    begin
      hit = (a == target[ADDR_W-1:0]);
    end
  endfunction

  wire sel_main   = hit(reg_addr_i, `MAIN_PROTECT_ADDR);
  wire sel_font   = hit(reg_addr_i, `FONT_PROTECT_ADDR);
  wire sel_status = hit(reg_addr_i, `PROTECT_STATUS_ADDR);

  // ****************************************************************
  // protect start registers
  // ****************************************************************
  // only bits 7..1 are stored; bit 0 has no flop at all
  reg [6:0] main_protect_start_bits;
  reg [6:0] font_protect_start_bits;

  // write data to stored bits: bit 0 of the write data is dropped
  function [6:0] store_bits;
    input [7:0] d;
    begin
      store_bits = d[`PROTECT_BITS_MSB:`PROTECT_BITS_LSB];
    end
  endfunction

  // one flop group per array so neither write can touch the other
  always @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n)
      main_protect_start_bits <= `PROTECT_RESET;
    else if (reg_write_i && sel_main)
      main_protect_start_bits <= store_bits(reg_wdata_i);
  end

  always @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n)
      font_protect_start_bits <= `PROTECT_RESET;
    else if (reg_write_i && sel_font)
      font_protect_start_bits <= store_bits(reg_wdata_i);
  end

  // ****************************************************************
  // per-array vectors
  // ****************************************************************
  // index 0 is the main array, index 1 the font array
  wire [1:0] program_sel = {font_program_select_i, main_program_select_i};
  wire [1:0] erase_sel   = {font_erase_select_i, main_erase_select_i};
  wire [1:0] hv_request  = {font_hv_request_i, main_hv_request_i};
  wire [1:0] any_sel     = program_sel | erase_sel;

  wire [1:0] write_in_array;
  wire [1:0] target_hit;

  reg  [ADDR_W-1:0] target_addr [0:1];
  reg  [1:0]        latched;
  reg  [1:0]        hv_on;
  reg  [1:0]        hv_req_q;
  reg  [1:0]        refused_sticky;
  reg  [1:0]        refuse_pulse;
  reg  [1:0]        target_guarded;

  // ****************************************************************
  // range checkers
  // ****************************************************************
  // flash writes are classified against the array they land in;
  // the latched address is what the protection check looks at
  protect_range #(
    .ARRAY_FIRST  (`MAIN_ARRAY_FIRST),
    .ARRAY_LAST   (`MAIN_ARRAY_LAST),
    .VECTOR_GUARD (1)
  ) u_main_write (
    .start_bits_i    (main_protect_start_bits),
    .addr_i          (flash_addr_i[15:0]),
    .in_array_o      (write_in_array[0]),
    .protected_hit_o ()
  );

  protect_range #(
    .ARRAY_FIRST  (`FONT_ARRAY_FIRST),
    .ARRAY_LAST   (`FONT_ARRAY_LAST),
    .VECTOR_GUARD (0)
  ) u_font_write (
    .start_bits_i    (font_protect_start_bits),
    .addr_i          (flash_addr_i[15:0]),
    .in_array_o      (write_in_array[1]),
    .protected_hit_o ()
  );

  protect_range #(
    .ARRAY_FIRST  (`MAIN_ARRAY_FIRST),
    .ARRAY_LAST   (`MAIN_ARRAY_LAST),
    .VECTOR_GUARD (1)
  ) u_main_target (
    .start_bits_i    (main_protect_start_bits),
    .addr_i          (target_addr[0][15:0]),
    .in_array_o      (),
    .protected_hit_o (target_hit[0])
  );

  protect_range #(
    .ARRAY_FIRST  (`FONT_ARRAY_FIRST),
    .ARRAY_LAST   (`FONT_ARRAY_LAST),
    .VECTOR_GUARD (0)
  ) u_font_target (
    .start_bits_i    (font_protect_start_bits),
    .addr_i          (target_addr[1][15:0]),
    .in_array_o      (),
    .protected_hit_o (target_hit[1])
  );

  // ****************************************************************
  // status register
  // ****************************************************************
  // refusal bits are the only writable status bits; a one clears
  wire status_clear = reg_write_i && sel_status;

  // status image: refusal flags, hv state and latch state per array
  function [7:0] status_image;
    input [1:0] refused_flags;
    input [1:0] hv_flags;
    input [1:0] latch_flags;
    begin
      status_image = {`STAT_PAD, refused_flags, hv_flags, latch_flags};
    end
  endfunction

  // ****************************************************************
  // sequence tracking and high-voltage gate
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_array
      // grant is judged only on a fresh request edge, so a register
      // change while hv already runs cannot drop it mid-pulse
      wire req_edge  = hv_request[g] && !hv_req_q[g];
      wire may_grant = any_sel[g] && latched[g];
      wire grant     = req_edge && may_grant && !target_hit[g];
      wire refuse    = req_edge && may_grant && target_hit[g];
      wire take_addr = flash_write_i && write_in_array[g] &&
                       any_sel[g] && !latched[g];
      wire drop_seq  = !any_sel[g] && !hv_on[g];
      wire clear_bit = status_clear &&
                       reg_wdata_i[`STAT_REFUSED_LSB + g];
      reg  next_latched;
      reg  next_hv_on;
      reg  next_refused;

      // the sequence ends only once both selects and hv are down
      always @* begin
        next_latched = latched[g];
        if (drop_seq)
          next_latched = 1'b0;
        else if (take_addr)
          next_latched = 1'b1;
      end

      // first in-array flash write of a sequence fixes the target
      always @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
          target_addr[g] <= {ADDR_W{1'b0}};
          latched[g]     <= 1'b0;
        end else begin
          latched[g] <= next_latched;
          if (take_addr)
            target_addr[g] <= flash_addr_i;
        end
      end

      // hv holds until its request drops, which lets the select clear
      // first as the erase and program sequences demand
      always @* begin
        next_hv_on = hv_on[g];
        if (!hv_request[g])
          next_hv_on = 1'b0;
        else if (grant)
          next_hv_on = 1'b1;
      end

      always @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
          hv_on[g]    <= 1'b0;
          hv_req_q[g] <= 1'b0;
        end else begin
          hv_on[g]    <= next_hv_on;
          hv_req_q[g] <= hv_request[g];
        end
      end

      // refusal flag: a new refusal beats a clear in the same cycle
      always @* begin
        next_refused = refused_sticky[g];
        if (refuse)
          next_refused = 1'b1;
        else if (clear_bit)
          next_refused = 1'b0;
      end

      always @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
          refused_sticky[g] <= 1'b0;
          refuse_pulse[g]   <= 1'b0;
          target_guarded[g] <= 1'b0;
        end else begin
          refused_sticky[g] <= next_refused;
          refuse_pulse[g]   <= refuse;
          target_guarded[g] <= latched[g] && target_hit[g];
        end
      end
    end
  endgenerate

  // ****************************************************************
  // read path
  // ****************************************************************
  reg [DATA_W-1:0] next_rdata;

  // protect register image: bit 0 reads zero as it has no storage
  function [7:0] reg_image;
    input [6:0] bits;
    begin
      reg_image = {bits, 1'b0};
    end
  endfunction

  always @* begin
    next_rdata = `READ_IDLE;
    if (reg_read_i) begin
      if (sel_main)
        next_rdata = reg_image(main_protect_start_bits);
      else if (sel_font)
        next_rdata = reg_image(font_protect_start_bits);
      else if (sel_status)
        next_rdata = status_image(refused_sticky, hv_on, latched);
    end
  end

  // data is valid only in the cycle after the strobe, zero elsewhere
  always @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n)
      reg_rdata_o <= `READ_IDLE;
    else
      reg_rdata_o <= next_rdata;
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  // all outputs are flops; the hv enables mirror the gate state one
  // cycle late, well inside the settling waits of the flash sequence
  always @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      main_high_voltage_enable_o <= 1'b0;
      main_target_addr_o         <= {ADDR_W{1'b0}};
      main_target_protected_o    <= 1'b0;
      main_hv_refused_o          <= 1'b0;
    end else begin
      main_high_voltage_enable_o <= hv_on[0];
      main_target_addr_o         <= target_addr[0];
      main_target_protected_o    <= target_guarded[0];
      main_hv_refused_o          <= refuse_pulse[0];
    end
  end

  always @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      font_high_voltage_enable_o <= 1'b0;
      font_target_addr_o         <= {ADDR_W{1'b0}};
      font_target_protected_o    <= 1'b0;
      font_hv_refused_o          <= 1'b0;
    end else begin
      font_high_voltage_enable_o <= hv_on[1];
      font_target_addr_o         <= target_addr[1];
      font_target_protected_o    <= target_guarded[1];
      font_hv_refused_o          <= refuse_pulse[1];
    end
  end

endmodule // flash_block_protect

// file: verif/flash_block_protect_checker.sv
// port assertions for the flash block-protection block
`timescale 1ns/1ps
`include "flash_block_protect_defs.vh"

module flash_block_protect_checker #(
  parameter ADDR_W = 16, // cpu address width
  parameter DATA_W = 8   // register data width
) (
  input wire              core_clk_i,                 // clock
  input wire              reset_n_i,                  // reset, low
  input wire              reg_read_i,                 // read strobe
  input wire [DATA_W-1:0] reg_rdata_o,                // read data
  input wire              main_program_select_i,      // main program
  input wire              main_erase_select_i,        // main erase
  input wire              main_hv_request_i,          // main request
  input wire              font_hv_request_i,          // font request
  input wire              main_high_voltage_enable_o, // main hv
  input wire              font_high_voltage_enable_o, // font hv
  input wire              main_target_protected_o,    // main guarded
  input wire              font_target_protected_o,    // font guarded
  input wire              main_hv_refused_o,          // main refusal
  input wire              font_hv_refused_o           // font refusal
);
  // ****************************************************************
  // properties
  // ****************************************************************
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);

  property p_rdata_idle;
    !reg_read_i |=> reg_rdata_o == `READ_IDLE;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data not idle without a read");
  property p_main_grant;
    $rose(main_high_voltage_enable_o) |-> !main_target_protected_o &&
      $past(main_hv_request_i, 2) &&
      ($past(main_program_select_i, 2) || $past(main_erase_select_i, 2));
  endproperty
  a_main_grant: assert property (p_main_grant)
    else $error("main hv granted without cause");
  property p_font_grant;
    $rose(font_high_voltage_enable_o) |->
      !font_target_protected_o && $past(font_hv_request_i, 2);
  endproperty
  a_font_grant: assert property (p_font_grant)
    else $error("font hv granted on guarded target");
  property p_main_refuse;
    main_hv_refused_o |-> main_target_protected_o &&
      !main_high_voltage_enable_o;
  endproperty
  a_main_refuse: assert property (p_main_refuse)
    else $error("main refusal without guarded target");
  property p_font_refuse;
    font_hv_refused_o |-> font_target_protected_o &&
      !font_high_voltage_enable_o;
  endproperty
  a_font_refuse: assert property (p_font_refuse)
    else $error("font refusal without guarded target");
  property p_refuse_pulse;
    main_hv_refused_o |=> !main_hv_refused_o;
  endproperty
  a_refuse_pulse: assert property (p_refuse_pulse)
    else $error("main refusal longer than one cycle");
  property p_main_drop;
    $fell(main_hv_request_i) |-> ##2 !main_high_voltage_enable_o;
  endproperty
  a_main_drop: assert property (p_main_drop)
    else $error("main hv stayed after request dropped");
  property p_font_drop;
    $fell(font_hv_request_i) |-> ##2 !font_high_voltage_enable_o;
  endproperty
  a_font_drop: assert property (p_font_drop)
    else $error("font hv stayed after request dropped");
endmodule // flash_block_protect_checker

bind flash_block_protect flash_block_protect_checker #(
  .ADDR_W(ADDR_W), .DATA_W(DATA_W)) chk (
  .core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
  .reg_read_i(reg_read_i), .reg_rdata_o(reg_rdata_o),
  .main_program_select_i(main_program_select_i),
  .main_erase_select_i(main_erase_select_i),
  .main_hv_request_i(main_hv_request_i),
  .font_hv_request_i(font_hv_request_i),
  .main_high_voltage_enable_o(main_high_voltage_enable_o),
  .font_high_voltage_enable_o(font_high_voltage_enable_o),
  .main_target_protected_o(main_target_protected_o),
  .font_target_protected_o(font_target_protected_o),
  .main_hv_refused_o(main_hv_refused_o),
  .font_hv_refused_o(font_hv_refused_o));

// file: verif/testbench.sv
// self-checking testbench for the flash block-protection block
`timescale 1ns/1ps
`include "flash_block_protect_defs.vh"

module testbench;
  reg         core_clk_i;
  reg         reset_n_i;
  reg  [15:0] reg_addr_i;
  reg  [7:0]  reg_wdata_i;
  reg         reg_write_i;
  reg         reg_read_i;
  wire [7:0]  reg_rdata_o;
  reg         flash_write_i;
  reg  [15:0] flash_addr_i;
  reg  [1:0]  prog_sel;  // index 0 main array, 1 font array
  reg  [1:0]  erase_sel;
  reg  [1:0]  hv_req;
  wire [1:0]  hv_en;
  wire [1:0]  refused;
  wire [1:0]  guarded;
  wire [15:0] main_target;
  wire [15:0] font_target;
  reg  [7:0]  rd_val;
  integer     fail_count;
  integer     comparisons;
  integer     i;

  flash_block_protect dut (
    .core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_write_i(reg_write_i), .reg_read_i(reg_read_i),
    .reg_rdata_o(reg_rdata_o), .flash_write_i(flash_write_i),
    .flash_addr_i(flash_addr_i),
    .main_program_select_i(prog_sel[0]), .main_erase_select_i(erase_sel[0]),
    .main_hv_request_i(hv_req[0]), .font_program_select_i(prog_sel[1]),
    .font_erase_select_i(erase_sel[1]), .font_hv_request_i(hv_req[1]),
    .main_high_voltage_enable_o(hv_en[0]),
    .font_high_voltage_enable_o(hv_en[1]),
    .main_target_addr_o(main_target), .font_target_addr_o(font_target),
    .main_target_protected_o(guarded[0]),
    .font_target_protected_o(guarded[1]),
    .main_hv_refused_o(refused[0]), .font_hv_refused_o(refused[1]));

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task check(input [15:0] seen, input [15:0] exp);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp) begin
        fail_count = fail_count + 1;
        $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
    end
  endtask

  task wr(input [15:0] a, input [7:0] d);
    begin
      @(posedge core_clk_i);
      reg_addr_i  <= a;
      reg_wdata_i <= d;
      reg_write_i <= 1'b1;
      @(posedge core_clk_i);
      reg_write_i <= 1'b0;
    end
  endtask

  // read data stand only in the cycle after the strobe
  task rd(input [15:0] a);
    begin
      @(posedge core_clk_i);
      reg_addr_i <= a;
      reg_read_i <= 1'b1;
      @(posedge core_clk_i);
      reg_read_i <= 1'b0;
      #1 rd_val = reg_rdata_o;
    end
  endtask

  // second flash write must not move the latched target
  task run(input f, input [7:0] bits, input [15:0] a1, input [15:0] a2,
           input er, input ok);
    reg seen_ref;
    begin
      wr(f ? `FONT_PROTECT_ADDR : `MAIN_PROTECT_ADDR, bits);
      prog_sel[f]  <= !er;
      erase_sel[f] <= er;
      @(posedge core_clk_i);
      flash_write_i <= 1'b1;
      flash_addr_i  <= a1;
      @(posedge core_clk_i);
      flash_addr_i <= a2;
      @(posedge core_clk_i);
      flash_write_i <= 1'b0;
      repeat (3) @(posedge core_clk_i);
      hv_req[f] <= 1'b1;
      seen_ref = 1'b0;
      repeat (5) begin
        @(posedge core_clk_i);
        #1 seen_ref = seen_ref | refused[f];
      end
      check(f ? font_target : main_target, a1);
      check(hv_en[f], ok);
      check(seen_ref, !ok);
      check(guarded[f], !ok);
      @(posedge core_clk_i);
      prog_sel[f]  <= 1'b0;
      erase_sel[f] <= 1'b0;
      @(posedge core_clk_i);
      hv_req[f] <= 1'b0;
      repeat (4) @(posedge core_clk_i);
      #1 check(hv_en[f], 1'b0);
    end
  endtask

  task t_regs;
    begin
      rd(`MAIN_PROTECT_ADDR);
      check(rd_val, 8'h00);
      rd(`FONT_PROTECT_ADDR);
      check(rd_val, 8'h00);
      wr(`MAIN_PROTECT_ADDR, 8'hff);
      wr(16'hfe09, 8'h55);
      rd(`MAIN_PROTECT_ADDR);
      check(rd_val, 8'hfe);
      rd(`FONT_PROTECT_ADDR);
      check(rd_val, 8'h00);
      rd(16'hfe09);
      check(rd_val, 8'h00);
      wr(`FONT_PROTECT_ADDR, 8'h3f);
      rd(`FONT_PROTECT_ADDR);
      check(rd_val, 8'h3e);
      rd(`MAIN_PROTECT_ADDR);
      check(rd_val, 8'hfe);
    end
  endtask

  task t_no_select;
    begin
      @(posedge core_clk_i);
      hv_req <= 2'b11;
      repeat (5) @(posedge core_clk_i);
      #1 check(hv_en, 2'b00);
      @(posedge core_clk_i);
      hv_req <= 2'b00;
    end
  endtask

  // main refusals leave only the main refusal flag set; a one clears it
  task t_status;
    begin
      rd(`PROTECT_STATUS_ADDR);
      check(rd_val, 8'h01 << `STAT_REFUSED_LSB);
      wr(`PROTECT_STATUS_ADDR, 8'h01 << `STAT_REFUSED_LSB);
      rd(`PROTECT_STATUS_ADDR);
      check(rd_val, 8'h00);
    end
  endtask

  task test_done;
    begin
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask

  // ****************************************************************
  // clock, watchdog and main sequence
  // ****************************************************************
  initial begin
    core_clk_i = 1'b0;
    forever #2.5 core_clk_i = ~core_clk_i;
  end

  initial begin
    repeat (5000) @(posedge core_clk_i);
    fail_count = fail_count + 1;
    test_done;
  end

  initial begin
    {reset_n_i, reg_write_i, reg_read_i, flash_write_i} = 4'h0;
    {reg_addr_i, flash_addr_i, reg_wdata_i} = 40'h0;
    {prog_sel, erase_sel, hv_req} = 6'h00;
    fail_count = 0;
    comparisons = 0;
    repeat (6) @(posedge core_clk_i);
    reset_n_i <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    t_regs;
    $display("register test done");
    t_no_select;
    $display("no select test done");
    run(0, 8'h40, 16'h4000, 16'h4000, 0, 0);
    run(0, 8'h40, 16'hffff, 16'hffff, 1, 0);
    run(0, 8'h3e, 16'h4000, 16'h4000, 1, 1);
    run(0, 8'h00, 16'hffff, 16'hffff, 0, 1);
    run(0, 8'h42, 16'h41ff, 16'h41ff, 0, 1);
    run(0, 8'h42, 16'h4200, 16'h4200, 1, 0);
    run(0, 8'h42, 16'h4000, 16'h4200, 0, 1);
    run(0, 8'hf8, 16'hf800, 16'hf800, 0, 0);
    for (i = 0; i < 3; i = i + 1) begin
      run(0, 8'hfa + 2 * i, 16'hffdf, 16'hffdf, i[0], 1);
      run(0, 8'hfa + 2 * i, 16'hffe0, 16'hffe0, !i[0], 0);
    end
    $display("main array test done");
    t_status;
    $display("status test done");
    run(1, 8'h0c, 16'h0c00, 16'h0c00, 0, 0);
    run(1, 8'h0c, 16'h3fff, 16'h3fff, 1, 0);
    run(1, 8'h0b, 16'h0c00, 16'h0c00, 0, 1);
    run(1, 8'h40, 16'h3fff, 16'h3fff, 1, 1);
    run(1, 8'hfe, 16'h3fff, 16'h3fff, 0, 1);
    run(1, 8'h3e, 16'h3dff, 16'h3dff, 0, 1);
    run(1, 8'h3e, 16'h3e00, 16'h3e00, 1, 0);
    $display("font array test done");
    test_done;
  end
endmodule // testbench
